// ### elp_pkg.sv
// constants and types shared by the exception and low-power controller
package elp_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [4:0] ADR_FLAGS_ONE = 5'h00;
    localparam logic [4:0] ADR_FLAGS_TWO = 5'h04;
    localparam logic [4:0] ADR_FLAGS_THREE = 5'h08;
    localparam logic [4:0] ADR_BRK_CTRL = 5'h0C;
    localparam logic [4:0] ADR_BRK_STAT = 5'h10;
    localparam logic [4:0] ADR_OPTION = 5'h14;
    localparam logic [4:0] ADR_MODE = 5'h18;
    // field positions
    localparam int BIT_BREAK_FLAG_CLEAR_ENABLE = 0;
    localparam int BIT_BREAK_WAIT_EXIT_FLAG = 1;
    localparam int BIT_SHORT_STOP_RECOVERY = 0;
    localparam int BIT_WDOG_DIS = 1;
    // reset values
    localparam logic [1:0] OPTION_RST = 2'h0;
    localparam logic BREAK_FLAG_CLEAR_ENABLE_RST = 1'b0;
    // sources and vector codes
    localparam int NUM_SRC = 20;
    localparam logic [4:0] VEC_SWI = 5'h00;
    // stop recovery in crystal clock cycles
    localparam int STOP_REC_LONG = 4096;
    localparam int STOP_REC_SHORT = 32;
    localparam int CNT_W = 13;
    typedef enum logic [2:0] {ST_RUN, ST_LATCHED, ST_WAIT, ST_STOP, ST_STOP_REC} elp_state_e;
endpackage

// ### elp_ctrl.sv
// exception arbitration, break flag protection and wait/stop control
// Operation
// - on interrupt entry the core stacks registers and the mask is set.
// - return from interrupt restores the stacked registers.
// - requests are latched and arbitrated; vector code held constant for fetch.
// - a latched interrupt is not preempted until serviced or mask cleared.
// - hardware interrupts taken at instruction end if unmasked and enabled.
// - highest priority first; pending request served before next instruction.
// - index high register is never stacked on interrupt entry.
// - software interrupt ignores mask and stacks pc, hardware stacks pc-1.
// - fixed order: reset, software interrupt, flag 1 down to lowest flag.
// - first flag register holds flags 6..1 in bits 7..2, bits 1..0 zero.
// - second flag register holds flags 14..7 in all eight bits.
// - third flag register holds flags 20..15 in bits 5..0, upper zero.
// - reset outranks everything and bypasses arbitration.
// - break forces the core to the software interrupt vector.
// - in break, peripheral flags cannot clear unless clear enable is set.
// - a flag cleared in break stays cleared after break ends.
// - two-step clears stay protected in break; second step after break clears.
// - wait or stop clears the mask and stops the core clock.
// - wait stops core clock only; enabled interrupt or reset wakes it.
// - break during wait sets the break wait-exit flag.
// - stop resets counter, gates both clocks; wake stacks after recovery.
// - stop recovery is 4096 crystal cycles, or 32 with short recovery set.
//
// The register offsets and the Wishbone register port were decided locally.
module elp_ctrl #(
    parameter int REC_LONG = elp_pkg::STOP_REC_LONG
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESETN_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // interrupt sources
    input wire logic [elp_pkg::NUM_SRC-1:0] INT_REQ_I,
    input wire logic [elp_pkg::NUM_SRC-1:0] INT_EN_I,
    input wire logic BREAK_I,
    // core status
    input wire logic INSTR_DONE_I,
    input wire logic IMASK_I,
    input wire logic SWI_EXEC_I,
    input wire logic RTI_EXEC_I,
    input wire logic WAIT_EXEC_I,
    input wire logic STOP_EXEC_I,
    input wire logic SVC_DONE_I,
    // core control
    output logic EXC_TAKE_O,
    output logic [4:0] VECTOR_O,
    output logic STACK_PC_DEC_O,
    output logic PUSH_INDEX_HI_O,
    output logic SET_IMASK_O,
    output logic CLR_IMASK_O,
    output logic RESTORE_O,
    // clocks and break
    output logic CPU_CLK_EN_O,
    output logic PER_CLK_EN_O,
    output logic XTAL_CLK_EN_O,
    output logic BREAK_ACTIVE_O,
    output logic FLAG_CLR_ALLOW_O,
    output logic WDOG_DIS_O
);
    elp_pkg::elp_state_e state_r, state_nxt;
    logic [4:0] vec_r;
    logic take_r;
    logic pc_dec_r;
    logic set_mask_r;
    logic clr_mask_r;
    logic restore_r;
    logic brk_act_r;
    logic break_flag_clear_enable_r;
    logic break_wait_exit_flag_r;
    logic [1:0] option_r;
    logic [elp_pkg::CNT_W-1:0] cnt_r;
    logic imask_q_r;
    logic ack_r;
    logic [31:0] rdat_r;

    // lowest flag number wins
    function automatic logic [4:0] elp_winner(input logic [elp_pkg::NUM_SRC-1:0] p);
        logic [4:0] w;
        w = 5'h00;
        for (int i = elp_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                w = 5'(i + 1);
            end
        end
        return w;
    endfunction

    // arbitration
    wire [elp_pkg::NUM_SRC-1:0] enabled = INT_REQ_I & INT_EN_I;
    wire any_en = |enabled;
    wire [4:0] win_code = elp_winner(enabled);
    wire hw_ok = any_en && !IMASK_I;
    wire mask_fall = imask_q_r && !IMASK_I;
    wire boundary = (state_r == elp_pkg::ST_RUN) && INSTR_DONE_I;
    wire swi_go = boundary && (SWI_EXEC_I || BREAK_I);
    wire hw_go = boundary && !swi_go && hw_ok;
    wire wait_go = boundary && !swi_go && !hw_go && WAIT_EXEC_I;
    wire stop_go = boundary && !swi_go && !hw_go && !wait_go && STOP_EXEC_I;
    // the mask is already cleared in wait, so any enabled request wakes
    wire wait_brk = (state_r == elp_pkg::ST_WAIT) && BREAK_I;
    wire wait_wake = (state_r == elp_pkg::ST_WAIT) && (BREAK_I || any_en);
    wire stop_wake = (state_r == elp_pkg::ST_STOP) && (BREAK_I || any_en);
    wire [elp_pkg::CNT_W-1:0] rec_len = option_r[elp_pkg::BIT_SHORT_STOP_RECOVERY]
        ? elp_pkg::CNT_W'(elp_pkg::STOP_REC_SHORT) : elp_pkg::CNT_W'(REC_LONG);
    wire rec_done = (state_r == elp_pkg::ST_STOP_REC) && (cnt_r == rec_len - 1'b1);
    wire rec_take = rec_done && (BREAK_I || any_en);
    wire rec_brk = rec_done && BREAK_I;
    wire take_now = swi_go || hw_go || wait_wake || rec_take;
    wire brk_sel = (boundary && BREAK_I) || wait_brk || rec_brk;
    wire is_swi = swi_go || wait_brk || rec_brk;
    wire [4:0] take_vec = is_swi ? elp_pkg::VEC_SWI : win_code;
    wire latch_end = SVC_DONE_I || mask_fall;

    // wishbone decode
    wire wb_req = WB_CYC_I && WB_STB_I && !ack_r;
    wire wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
    wire wr_brk_ctrl = wb_wr && (WB_ADR_I == elp_pkg::ADR_BRK_CTRL);
    wire wr_brk_stat = wb_wr && (WB_ADR_I == elp_pkg::ADR_BRK_STAT);
    wire wr_option = wb_wr && (WB_ADR_I == elp_pkg::ADR_OPTION);
    wire [7:0] flags_one = {INT_REQ_I[5:0], 2'b00};
    wire [7:0] flags_two = INT_REQ_I[13:6];
    wire [7:0] flags_three = {2'b00, INT_REQ_I[19:14]};
    wire [31:0] rd_mux =
        (WB_ADR_I == elp_pkg::ADR_FLAGS_ONE) ? {24'h000000, flags_one} :
        (WB_ADR_I == elp_pkg::ADR_FLAGS_TWO) ? {24'h000000, flags_two} :
        (WB_ADR_I == elp_pkg::ADR_FLAGS_THREE) ? {24'h000000, flags_three} :
        (WB_ADR_I == elp_pkg::ADR_BRK_CTRL) ? {31'h0000000, break_flag_clear_enable_r} :
        (WB_ADR_I == elp_pkg::ADR_BRK_STAT) ? {30'h0000000, break_wait_exit_flag_r, 1'b0} :
        (WB_ADR_I == elp_pkg::ADR_OPTION) ? {30'h0000000, option_r} :
        (WB_ADR_I == elp_pkg::ADR_MODE) ? {24'h000000, brk_act_r, vec_r, 2'(state_r)} :
        32'h00000000;
    // break_wait_exit_flag: a break exit in the clearing cycle wins over the write of zero
    wire break_wait_exit_flag_nxt = wait_brk ? 1'b1 : (wr_brk_stat ? WB_DAT_I[elp_pkg::BIT_BREAK_WAIT_EXIT_FLAG] : break_wait_exit_flag_r);

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            elp_pkg::ST_RUN:
            begin
                if (swi_go || hw_go)
                begin
                    state_nxt = elp_pkg::ST_LATCHED;
                end
                else if (wait_go)
                begin
                    state_nxt = elp_pkg::ST_WAIT;
                end
                else if (stop_go)
                begin
                    state_nxt = elp_pkg::ST_STOP;
                end
            end
            elp_pkg::ST_LATCHED:
            begin
                if (latch_end)
                begin
                    state_nxt = elp_pkg::ST_RUN;
                end
            end
            elp_pkg::ST_WAIT:
            begin
                if (wait_wake)
                begin
                    state_nxt = elp_pkg::ST_LATCHED;
                end
            end
            elp_pkg::ST_STOP:
            begin
                if (stop_wake)
                begin
                    state_nxt = elp_pkg::ST_STOP_REC;
                end
            end
            elp_pkg::ST_STOP_REC:
            begin
                if (rec_done)
                begin
                    state_nxt = rec_take ? elp_pkg::ST_LATCHED : elp_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_nxt = elp_pkg::ST_RUN;
            end
        endcase
    end

    // reset takes no part in arbitration: it simply returns everything to run
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            state_r <= elp_pkg::ST_RUN;
            vec_r <= elp_pkg::VEC_SWI;
            take_r <= 1'b0;
            pc_dec_r <= 1'b0;
            set_mask_r <= 1'b0;
            clr_mask_r <= 1'b0;
            restore_r <= 1'b0;
            imask_q_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            if (take_now)
            begin
                vec_r <= take_vec;
                pc_dec_r <= !is_swi;
            end
            take_r <= take_now;
            set_mask_r <= take_now;
            clr_mask_r <= wait_go || stop_go;
            restore_r <= RTI_EXEC_I;
            imask_q_r <= IMASK_I;
        end
    end

    // stop counter is held clear from stop entry until recovery starts
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I || state_r != elp_pkg::ST_STOP_REC)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // break state runs from the forced vector until the return
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            brk_act_r <= 1'b0;
        end
        else if (take_now && brk_sel)
        begin
            brk_act_r <= 1'b1;
        end
        else if (RTI_EXEC_I)
        begin
            brk_act_r <= 1'b0;
        end
    end

    // registers
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RESETN_I)
        begin
            break_flag_clear_enable_r <= elp_pkg::BREAK_FLAG_CLEAR_ENABLE_RST;
            break_wait_exit_flag_r <= 1'b0;
            option_r <= elp_pkg::OPTION_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end
        else
        begin
            if (wr_brk_ctrl)
            begin
                break_flag_clear_enable_r <= WB_DAT_I[elp_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE];
            end
            if (wr_option)
            begin
                option_r <= WB_DAT_I[1:0];
            end
            break_wait_exit_flag_r <= break_wait_exit_flag_nxt;
            ack_r <= wb_req;
            if (wb_req)
            begin
                rdat_r <= rd_mux;
            end
        end
    end

    // outputs
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdat_r;
    assign EXC_TAKE_O = take_r;
    assign VECTOR_O = vec_r;
    assign STACK_PC_DEC_O = pc_dec_r;
    assign PUSH_INDEX_HI_O = 1'b0;
    assign SET_IMASK_O = set_mask_r;
    assign CLR_IMASK_O = clr_mask_r;
    assign RESTORE_O = restore_r;
    assign CPU_CLK_EN_O = (state_r == elp_pkg::ST_RUN) || (state_r == elp_pkg::ST_LATCHED);
    assign PER_CLK_EN_O = (state_r != elp_pkg::ST_STOP) && (state_r != elp_pkg::ST_STOP_REC);
    assign XTAL_CLK_EN_O = (state_r != elp_pkg::ST_STOP);
    assign BREAK_ACTIVE_O = brk_act_r;
    // peripherals sample this at their clearing step, so a first step taken
    // before break still cannot complete a clear while break holds
    assign FLAG_CLR_ALLOW_O = !brk_act_r || break_flag_clear_enable_r;
    assign WDOG_DIS_O = option_r[elp_pkg::BIT_WDOG_DIS];

    // checks
    a_swi_no_mask: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        boundary && SWI_EXEC_I && IMASK_I |=> EXC_TAKE_O && VECTOR_O == elp_pkg::VEC_SWI && !STACK_PC_DEC_O)
        else $error("software interrupt not taken under mask");
    a_mask_blocks_hw: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        boundary && IMASK_I && !SWI_EXEC_I && !BREAK_I |=> !EXC_TAKE_O)
        else $error("hardware interrupt taken while masked");
    a_latch_holds: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        state_r == elp_pkg::ST_LATCHED && $past(state_r) == elp_pkg::ST_LATCHED |-> $stable(VECTOR_O))
        else $error("latched vector changed");
    a_hw_priority: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        hw_go && enabled[0] |=> VECTOR_O == 5'h01 && STACK_PC_DEC_O && SET_IMASK_O)
        else $error("flag one lost arbitration");
    a_wait_clocks: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wait_go |=> CLR_IMASK_O && !CPU_CLK_EN_O && PER_CLK_EN_O)
        else $error("wait entry wrong");
    a_break_wait_exit_flag_set: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wait_brk |=> break_wait_exit_flag_r ##1 EXC_TAKE_O == 1'b0)
        else $error("break wait-exit flag not set");
    a_stop_gates: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        stop_go |=> !XTAL_CLK_EN_O && !PER_CLK_EN_O && cnt_r == '0)
        else $error("stop entry wrong");
    a_stop_rec_len: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        state_r == elp_pkg::ST_STOP_REC && option_r[elp_pkg::BIT_SHORT_STOP_RECOVERY] && cnt_r == '0 && $stable(option_r)
        |-> ##31 rec_done || $changed(option_r))
        else $error("short stop recovery length wrong");
    a_brk_protect: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        BREAK_ACTIVE_O && !break_flag_clear_enable_r |-> !FLAG_CLR_ALLOW_O)
        else $error("flag clear allowed in break");
    // reset, exception, status read, break and low-power checks
    a_reset_to_run: assert property (@(posedge CORE_CLK_I)
        !RESETN_I |=> state_r == elp_pkg::ST_RUN && !EXC_TAKE_O && !BREAK_ACTIVE_O && CPU_CLK_EN_O)
        else $error("reset did not return to run");
    a_take_sets_mask: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        EXC_TAKE_O |-> SET_IMASK_O)
        else $error("take without mask set");
    a_restore_pulse: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        RTI_EXEC_I |=> RESTORE_O)
        else $error("return did not restore");
    a_no_preempt: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        state_r == elp_pkg::ST_LATCHED |=> !EXC_TAKE_O)
        else $error("latched interrupt preempted");
    a_flags_one_map: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wb_req && WB_ADR_I == elp_pkg::ADR_FLAGS_ONE |=> WB_DAT_O[7:0] == {$past(INT_REQ_I[5:0]), 2'b00})
        else $error("first flag register wrong");
    a_flags_two_map: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wb_req && WB_ADR_I == elp_pkg::ADR_FLAGS_TWO |=> WB_DAT_O[7:0] == $past(INT_REQ_I[13:6]))
        else $error("second flag register wrong");
    a_flags_three_map: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wb_req && WB_ADR_I == elp_pkg::ADR_FLAGS_THREE |=> WB_DAT_O[7:0] == {2'b00, $past(INT_REQ_I[19:14])})
        else $error("third flag register wrong");
    a_break_vector: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        take_now && brk_sel |=> VECTOR_O == elp_pkg::VEC_SWI && BREAK_ACTIVE_O)
        else $error("break not forced to software vector");
    a_clear_enable: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        break_flag_clear_enable_r |-> FLAG_CLR_ALLOW_O)
        else $error("clear enable ignored");
    a_stop_mask: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        stop_go |=> CLR_IMASK_O && !CPU_CLK_EN_O)
        else $error("stop entry left mask or core clock");
    a_wait_wake: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        wait_wake |=> EXC_TAKE_O && state_r == elp_pkg::ST_LATCHED)
        else $error("wait wake not taken next cycle");
    a_rec_no_take: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
        state_r == elp_pkg::ST_STOP_REC && !rec_done |=> !EXC_TAKE_O)
        else $error("stacking before stop recovery ended");
endmodule // elp_ctrl

// ### elp_core_model.sv
// core model: instruction boundaries, mask bit and vector fetch
module elp_core_model #(
    parameter int SVC_LAT = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // controls from the controller
    input wire logic cpu_clk_en_i,
    input wire logic set_imask_i,
    input wire logic clr_imask_i,
    input wire logic restore_i,
    input wire logic take_i,
    // core status
    output logic instr_done_o,
    output logic imask_o,
    output logic svc_done_o
);
    logic [1:0] phase_r;
    int svc_cnt_r;
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            phase_r <= 2'h0;
            instr_done_o <= 1'b0;
            imask_o <= 1'b0;
            svc_cnt_r <= 0;
            svc_done_o <= 1'b0;
        end
        else
        begin
            // boundaries only while clocked, so a gated core stays silent
            phase_r <= phase_r + {1'b0, cpu_clk_en_i};
            instr_done_o <= cpu_clk_en_i && phase_r == 2'h3;
            if (set_imask_i)
                imask_o <= 1'b1;
            else if (clr_imask_i || restore_i)
                imask_o <= 1'b0;
            // slow vector fetch keeps the latched period open a while
            svc_cnt_r <= take_i ? SVC_LAT : (svc_cnt_r != 0 ? svc_cnt_r - 1 : 0);
            svc_done_o <= svc_cnt_r == 1;
        end
    end
endmodule // elp_core_model

// ### tb_top.sv
// testbench for the exception and low-power controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REC = 64;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [4:0] adr = 5'h00;
    logic [4:0] vec;
    logic [31:0] wdat = 32'h0, rdat;
    logic [19:0] req = 20'h0, en = 20'hFFFFF;
    logic brk = 1'b0, software_interrupt_instr = 1'b0, return_from_interrupt_instr = 1'b0, wt = 1'b0, stp = 1'b0;
    logic idone, imask, svc, take, spc, pih, seti, clri, rest, cpu_en, per_en, xtal_en, brk_act, allow, wdog;
    int fails = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    elp_ctrl #(.REC_LONG(REC)) elp_ctrl_i (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .INT_REQ_I(req), .INT_EN_I(en), .BREAK_I(brk), .INSTR_DONE_I(idone),
        .IMASK_I(imask), .SWI_EXEC_I(software_interrupt_instr), .RTI_EXEC_I(return_from_interrupt_instr), .WAIT_EXEC_I(wt), .STOP_EXEC_I(stp),
        .SVC_DONE_I(svc), .EXC_TAKE_O(take), .VECTOR_O(vec), .STACK_PC_DEC_O(spc),
        .PUSH_INDEX_HI_O(pih), .SET_IMASK_O(seti), .CLR_IMASK_O(clri), .RESTORE_O(rest),
        .CPU_CLK_EN_O(cpu_en), .PER_CLK_EN_O(per_en), .XTAL_CLK_EN_O(xtal_en),
        .BREAK_ACTIVE_O(brk_act), .FLAG_CLR_ALLOW_O(allow), .WDOG_DIS_O(wdog));
    elp_core_model #(.SVC_LAT(6)) elp_core_model_i (.clk_i(clk), .rst_n_i(rst_n), .cpu_clk_en_i(cpu_en),
        .set_imask_i(seti), .clr_imask_i(clri), .restore_i(rest), .take_i(take),
        .instr_done_o(idone), .imask_o(imask), .svc_done_o(svc));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sel: 0 take, 1 service done, 2 core clock, 3 crystal clock
    task automatic wait_lvl(input int sel, input logic v, output int n);
        logic s;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            s = sel == 0 ? take : sel == 1 ? svc : sel == 2 ? cpu_en : xtal_en;
        end
        while (s !== v && n < 5000);
        if (s !== v)
        begin
            fails++;
            $display("Error wait %0d expected %b seen %b", sel, v, s);
            conclude();
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        logic ok;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        ok = ack === 1'b1;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (!ok)
        begin
            fails++;
            $display("Error ack expected 1 seen 0");
            conclude();
        end
    endtask
    task automatic ret();
        return_from_interrupt_instr <= 1'b1;
        @(posedge clk);
        return_from_interrupt_instr <= 1'b0;
        @(posedge clk);
        chk("restore", 32'h1, {31'h0, rest});
        @(posedge clk);
    endtask
    task automatic service();
        int n;
        wait_lvl(1, 1'b1, n);
        ret();
    endtask
    task automatic take_chk(input logic [4:0] v, input logic dec);
        int n;
        wait_lvl(0, 1'b1, n);
        chk("vector", {27'h0, v}, {27'h0, vec});
        chk("pc minus one", {31'h0, dec}, {31'h0, spc});
        chk("index high push", 32'h0, {31'h0, pih});
        chk("set mask", 32'h1, {31'h0, seti});
    endtask
    task automatic s_regs();
        logic [31:0] q;
        logic [19:0] r;
        r = 20'hB5A6C;
        en <= 20'h00000;
        req <= r;
        @(posedge clk);
        wb(1'b0, elp_pkg::ADR_OPTION, 32'h0, q);
        chk("option reset", {30'h0, elp_pkg::OPTION_RST}, q);
        wb(1'b0, elp_pkg::ADR_FLAGS_ONE, 32'h0, q);
        chk("flags one", {24'h0, r[5:0], 2'b00}, q);
        wb(1'b0, elp_pkg::ADR_FLAGS_TWO, 32'h0, q);
        chk("flags two", {24'h0, r[13:6]}, q);
        wb(1'b0, elp_pkg::ADR_FLAGS_THREE, 32'h0, q);
        chk("flags three", {26'h0, r[19:14]}, q);
        wb(1'b0, 5'h1C, 32'h0, q);
        chk("unmapped", 32'h0, q);
        chk("disabled no take", 32'h0, {31'h0, take});
        req <= 20'h0;
        en <= 20'hFFFFF;
        @(posedge clk);
    endtask
    task automatic s_hw();
        int n;
        req <= 20'h00014;
        take_chk(5'h03, 1'b1);
        req <= 20'h00011;
        repeat (3) @(posedge clk);
        chk("no preempt take", 32'h0, {31'h0, take});
        chk("held vector", 32'h3, {27'h0, vec});
        service();
        take_chk(5'h01, 1'b1);
        req <= 20'h00010;
        service();
        take_chk(5'h05, 1'b1);
        req <= 20'h0;
        wait_lvl(1, 1'b1, n);
        software_interrupt_instr <= 1'b1;
        take_chk(elp_pkg::VEC_SWI, 1'b0);
        software_interrupt_instr <= 1'b0;
        // no return: the mask stays set so wait entry has to clear it
        wait_lvl(1, 1'b1, n);
    endtask
    task automatic s_wait();
        logic [31:0] q;
        int n;
        chk("mask before wait", 32'h1, {31'h0, imask});
        wt <= 1'b1;
        wait_lvl(2, 1'b0, n);
        wt <= 1'b0;
        @(posedge clk);
        chk("wait mask", 32'h0, {31'h0, imask});
        chk("wait peripheral clock", 32'h1, {31'h0, per_en});
        req <= 20'h00002;
        wait_lvl(0, 1'b1, n);
        chk("wait wake prompt", 32'h1, {31'h0, n <= 3});
        chk("wait vector", 32'h2, {27'h0, vec});
        req <= 20'h0;
        service();
        wt <= 1'b1;
        wait_lvl(2, 1'b0, n);
        wt <= 1'b0;
        brk <= 1'b1;
        take_chk(elp_pkg::VEC_SWI, 1'b0);
        brk <= 1'b0;
        @(posedge clk);
        chk("break active", 32'h1, {31'h0, brk_act});
        chk("protect flags", 32'h0, {31'h0, allow});
        wb(1'b1, elp_pkg::ADR_BRK_CTRL, 32'h1, q);
        chk("clear enable", 32'h1, {31'h0, allow});
        wb(1'b0, elp_pkg::ADR_BRK_STAT, 32'h0, q);
        chk("break wait exit", 32'h2, q);
        wb(1'b1, elp_pkg::ADR_BRK_CTRL, 32'h0, q);
        // the vector fetch finished during the bus accesses, so only return
        ret();
        chk("break left", 32'h0, {31'h0, brk_act});
    endtask
    task automatic s_stop(input logic short_stop_recovery, input int rec);
        logic [31:0] q;
        int n;
        wb(1'b1, elp_pkg::ADR_OPTION, {30'h0, short_stop_recovery, short_stop_recovery}, q);
        wb(1'b0, elp_pkg::ADR_OPTION, 32'h0, q);
        chk("option readback", {30'h0, short_stop_recovery, short_stop_recovery}, q);
        chk("watchdog disable", {31'h0, short_stop_recovery}, {31'h0, wdog});
        stp <= 1'b1;
        wait_lvl(3, 1'b0, n);
        stp <= 1'b0;
        @(posedge clk);
        chk("stop peripheral clock", 32'h0, {31'h0, per_en});
        chk("stop core clock", 32'h0, {31'h0, cpu_en});
        req <= 20'h00008;
        wait_lvl(0, 1'b1, n);
        chk("recovery span", 32'h1, {31'h0, n >= rec && n <= rec + 4});
        chk("stop vector", 32'h4, {27'h0, vec});
        req <= 20'h0;
        service();
    endtask
    task automatic s_reset();
        int n;
        req <= 20'h00001;
        wait_lvl(0, 1'b1, n);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset vector", {27'h0, elp_pkg::VEC_SWI}, {27'h0, vec});
        chk("reset core clock", 32'h1, {31'h0, cpu_en});
        req <= 20'h0;
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset no take", 32'h0, {31'h0, take});
        chk("reset clear allowed", 32'h1, {31'h0, allow});
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        s_regs();
        s_hw();
        s_wait();
        s_stop(1'b1, elp_pkg::STOP_REC_SHORT);
        s_stop(1'b0, REC);
        s_reset();
        conclude();
    end
endmodule // tb_top
